/* File: core/epps_core.sv */
// protected page cache paging-state engine with register port
// What this block does
// - block op blocks page, stops new translations
// - uncached access to blocked page faults
// - track op starts epoch for enclave
// - evict encrypts, exports, invalidates page
// - evict makes MAC; reload needs match
// - evict records version in version slot
// - reload leaves page unblocked or blocked
// - reload empties referenced version slot
// - control page evicted only after children
// - dynamic add only on free page
// - dynamic add leaves page valid, pending
// - dynamic page regular type, zero contents
// - accept checks attributes, clears pending
// - dynamic ops need second-generation support
// - interrupt in enclave forces exit, flush
// - re-entry during tracking needs no shootdown
module epps_core import epps_pkg::*; #(
  parameter int NLP = 4,
  parameter logic GEN2_SUPPORT = 1'b1,
  parameter logic [DATA_W-1:0] SEAL_KEY = 32'h5A3C96E1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // translation lookups
  input wire logic xlate_req,
  input wire logic [PG_W-1:0] xlate_page,
  input wire logic xlate_cached,
  output logic xlate_done,
  output logic xlate_fault,
  output logic xlate_new,
  // logical processors
  input wire logic [NLP-1:0] lp_in_enclave,
  input wire logic [NLP-1:0] lp_ipi,
  input wire logic [NLP-1:0] lp_exit,
  output logic [NLP-1:0] lp_aex_flush
);
  localparam int NSLOT = 2**SLOT_W;

  epps_state_type state_q, state_d;
  logic [DATA_W-1:0] cmd_q, cmd_d, din_q, din_d, min_q, min_d;
  logic [DATA_W-1:0] img_q, img_d, mout_q, mout_d, rdata_q, rdata_d;
  epps_err_type err_q, err_d, err_c;
  epps_page_type pg_q [NPAGES];
  epps_page_type pg_d [NPAGES];
  logic [NSLOT-1:0] sfull_q, sfull_d;
  logic [VER_W-1:0] ver_q, ver_d, vm_rdata;
  logic trk_act_q, trk_act_d;
  logic [PG_W-1:0] trk_enclave_control_page_q, trk_enclave_control_page_d;
  logic [NLP-1:0] trk_pend_q, trk_pend_d, aex_q, aex_d;
  logic xdone_q, xdone_d, xfault_q, xfault_d, xnew_q, xnew_d;
  epps_op_type op;
  logic [PG_W-1:0] pg, enclave_control_page, va;
  logic [SLOT_W-1:0] slot;
  epps_ptype_type ctype;
  logic exec, exec_ok, is_evict, is_reload, child_c, trk_done, slot_ok;
  logic parent_ok, vm_we;
  logic [DATA_W-1:0] ks_c, mac_c, cipher_c;
  logic [PG_W-1:0] seal_owner;
  epps_ptype_type seal_type;

  // command decode
  assign op = epps_op_type'(cmd_q[OP_LSB +: 4]);
  assign pg = cmd_q[PAGE_LSB +: PG_W];
  assign slot = cmd_q[SLOT_LSB +: SLOT_W];
  assign enclave_control_page = cmd_q[ENCLAVE_CONTROL_PAGE_LSB +: PG_W];
  assign ctype = epps_ptype_type'(cmd_q[TYPE_LSB +: 2]);
  assign va = slot[SLOT_W-1 -: PG_W];
  assign exec = state_q == ST_EXEC;
  assign exec_ok = exec && err_c == ERR_NONE;
  assign is_evict = op == OP_PAGE_EVICT;
  assign is_reload = op == OP_RELOAD_UNBLOCKED || op == OP_RELOAD_BLOCKED;
  assign trk_done = trk_act_q && trk_pend_q == '0;
  assign vm_we = exec_ok && is_evict;

  // slot page resident, of version type, distinct from target
  assign slot_ok = pg_q[va].valid && pg_q[va].ptype == PT_VERSION &&
                   va != pg;
  assign parent_ok = ctype != PT_REGULAR ||
                     (pg_q[enclave_control_page].valid && pg_q[enclave_control_page].ptype == PT_CONTROL);

  // live children of the control page named by the command
  always_comb begin
    child_c = 1'b0;
    for (int i = 0; i < NPAGES; i++) begin
      if (pg_q[i].valid && pg_q[i].ptype == PT_REGULAR &&
          pg_q[i].owner == pg) begin
        child_c = 1'b1;
      end
    end
  end

  // sealing context: page table on eviction, command on reload
  assign seal_owner = is_evict ? pg_q[pg].owner : enclave_control_page;
  assign seal_type = is_evict ? pg_q[pg].ptype : ctype;
  assign cipher_c = is_evict ? (pg_q[pg].data ^ ks_c) : din_q;

  epps_seal #(.KEY(SEAL_KEY)) u_seal (
    .version(is_evict ? ver_q : vm_rdata),
    .page(pg),
    .ptype(seal_type),
    .owner(seal_owner),
    .cipher(cipher_c),
    .keystream(ks_c),
    .mac(mac_c)
  );

  epps_vmem #(.AW(SLOT_W), .DW(VER_W)) u_vmem (
    .core_clk(core_clk),
    .rst(rst),
    .we(vm_we),
    .waddr(slot),
    .wdata(ver_q),
    .re(state_q == ST_READ),
    .raddr(slot),
    .rdata_q(vm_rdata)
  );

  // operation checks
  always_comb begin
    err_c = ERR_NONE;
    unique case (op)
      OP_PAGE_BLOCK: begin
        if (!pg_q[pg].valid || pg_q[pg].ptype != PT_REGULAR ||
            pg_q[pg].blocked) err_c = ERR_STATE;
      end
      OP_TRANSLATION_TRACK: begin
        if (!pg_q[pg].valid || pg_q[pg].ptype != PT_CONTROL) begin
          err_c = ERR_STATE;
        end else if (trk_act_q && !trk_done) begin
          err_c = ERR_TRACK;
        end
      end
      OP_PAGE_EVICT: begin
        if (!pg_q[pg].valid) begin
          err_c = ERR_STATE;
        end else if (!slot_ok || sfull_q[slot]) begin
          err_c = ERR_SLOT;
        end else if (pg_q[pg].ptype == PT_CONTROL && child_c) begin
          err_c = ERR_CHILD;
        end else if (pg_q[pg].ptype == PT_REGULAR &&
                     !pg_q[pg].blocked) begin
          err_c = ERR_STATE;
        end else if (pg_q[pg].ptype == PT_REGULAR &&
                     !(pg_q[pg].tracked && trk_done &&
                       trk_enclave_control_page_q == pg_q[pg].owner)) begin
          err_c = ERR_TRACK;
        end
      end
      OP_RELOAD_UNBLOCKED, OP_RELOAD_BLOCKED: begin
        if (pg_q[pg].valid) begin
          err_c = ERR_STATE;
        end else if (!slot_ok || !sfull_q[slot]) begin
          err_c = ERR_SLOT;
        end else if (!parent_ok) begin
          err_c = ERR_PARENT;
        end else if (mac_c != min_q) begin
          err_c = ERR_MAC;
        end
      end
      OP_VERSION_PAGE_CREATE: begin
        if (pg_q[pg].valid) err_c = ERR_STATE;
      end
      OP_DYNAMIC_PAGE_ADD: begin
        if (!GEN2_SUPPORT) begin
          err_c = ERR_UNSUP;
        end else if (pg_q[pg].valid) begin
          err_c = ERR_STATE;
        end else if (!pg_q[enclave_control_page].valid ||
                     pg_q[enclave_control_page].ptype != PT_CONTROL) begin
          err_c = ERR_PARENT;
        end
      end
      OP_ENCLAVE_ACCEPT: begin
        if (!GEN2_SUPPORT) begin
          err_c = ERR_UNSUP;
        end else if (!pg_q[pg].valid || !pg_q[pg].pending ||
                     pg_q[pg].ptype != PT_REGULAR ||
                     pg_q[pg].owner != enclave_control_page) begin
          err_c = ERR_STATE;
        end
      end
      OP_PAGE_INSTALL: begin
        if (pg_q[pg].valid) begin
          err_c = ERR_STATE;
        end else if (!parent_ok) begin
          err_c = ERR_PARENT;
        end
      end
      default: err_c = ERR_BADOP;
    endcase
  end

  // page table, version slots and tracker next state
  always_comb begin
    pg_d = pg_q;
    sfull_d = sfull_q;
    ver_d = ver_q;
    img_d = img_q;
    mout_d = mout_q;
    err_d = exec ? err_c : err_q;
    trk_act_d = trk_act_q;
    trk_enclave_control_page_d = trk_enclave_control_page_q;
    trk_pend_d = trk_pend_q & ~(lp_exit | aex_q);
    if (exec_ok) begin
      unique case (op)
        OP_PAGE_BLOCK: begin
          pg_d[pg].blocked = 1'b1;
          pg_d[pg].tracked = 1'b0;
        end
        OP_TRANSLATION_TRACK: begin
          trk_act_d = 1'b1;
          trk_enclave_control_page_d = pg;
          trk_pend_d = lp_in_enclave & ~(lp_exit | aex_q);
          for (int i = 0; i < NPAGES; i++) begin
            if (pg_q[i].valid && pg_q[i].blocked &&
                pg_q[i].owner == pg) pg_d[i].tracked = 1'b1;
          end
        end
        OP_PAGE_EVICT: begin
          pg_d[pg] = '0;
          img_d = cipher_c;
          mout_d = mac_c;
          sfull_d[slot] = 1'b1;
          ver_d = ver_q + 16'h0001;
        end
        OP_RELOAD_UNBLOCKED, OP_RELOAD_BLOCKED: begin
          pg_d[pg].valid = 1'b1;
          pg_d[pg].blocked = op == OP_RELOAD_BLOCKED;
          pg_d[pg].pending = 1'b0;
          pg_d[pg].tracked = 1'b0;
          pg_d[pg].ptype = ctype;
          pg_d[pg].owner = enclave_control_page;
          pg_d[pg].data = din_q ^ ks_c;
          sfull_d[slot] = 1'b0;
        end
        OP_VERSION_PAGE_CREATE: begin
          pg_d[pg] = '0;
          pg_d[pg].valid = 1'b1;
          pg_d[pg].ptype = PT_VERSION;
          sfull_d[{pg, 2'b00} +: 4] = 4'h0;
        end
        OP_DYNAMIC_PAGE_ADD: begin
          pg_d[pg] = '0;
          pg_d[pg].valid = 1'b1;
          pg_d[pg].pending = 1'b1;
          pg_d[pg].ptype = PT_REGULAR;
          pg_d[pg].owner = enclave_control_page;
        end
        OP_ENCLAVE_ACCEPT: pg_d[pg].pending = 1'b0;
        OP_PAGE_INSTALL: begin
          pg_d[pg] = '0;
          pg_d[pg].valid = 1'b1;
          pg_d[pg].ptype = ctype;
          pg_d[pg].owner = enclave_control_page;
          pg_d[pg].data = din_q;
        end
        default: ;
      endcase
    end
  end

  // register port, sequencer, translations and processor exits
  always_comb begin
    cmd_d = cmd_q;
    din_d = din_q;
    min_d = min_q;
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (reg_wr && reg_addr == REG_CMD) begin
        cmd_d = reg_wdata;
        state_d = ST_READ;
      end
      ST_READ: state_d = ST_EXEC;
      ST_EXEC: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    if (reg_wr && reg_addr == REG_DATA_IN) din_d = reg_wdata;
    if (reg_wr && reg_addr == REG_MAC_IN) min_d = reg_wdata;
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_CMD: rdata_d = cmd_q;
        REG_DATA_IN: rdata_d = din_q;
        REG_MAC_IN: rdata_d = min_q;
        REG_STATUS: rdata_d = {25'h0, trk_done, trk_act_q,
                               state_q != ST_IDLE, err_q};
        REG_IMG_OUT: rdata_d = img_q;
        REG_MAC_OUT: rdata_d = mout_q;
        REG_FEATURE: rdata_d = {30'h0, GEN2_SUPPORT, 1'b1};
        REG_PAGE_INFO: rdata_d = {20'h0, pg_q[din_q[PG_W-1:0]].owner, 2'b00,
          pg_q[din_q[PG_W-1:0]].ptype, pg_q[din_q[PG_W-1:0]].tracked,
          pg_q[din_q[PG_W-1:0]].pending, pg_q[din_q[PG_W-1:0]].blocked,
          pg_q[din_q[PG_W-1:0]].valid};
        default: rdata_d = '0;
      endcase
    end
    xdone_d = xlate_req;
    xfault_d = xlate_req && !xlate_cached && (!pg_q[xlate_page].valid ||
               pg_q[xlate_page].blocked || pg_q[xlate_page].pending);
    xnew_d = xlate_req && !xlate_cached && !xfault_d;
    aex_d = lp_ipi & lp_in_enclave;
  end

  // state registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      din_q <= '0;
      min_q <= '0;
      img_q <= '0;
      mout_q <= '0;
      rdata_q <= '0;
      err_q <= ERR_NONE;
      for (int i = 0; i < NPAGES; i++) pg_q[i] <= '0;
      sfull_q <= '0;
      ver_q <= VER_RST;
      trk_act_q <= 1'b0;
      trk_enclave_control_page_q <= '0;
      trk_pend_q <= '0;
      aex_q <= '0;
      xdone_q <= 1'b0;
      xfault_q <= 1'b0;
      xnew_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      din_q <= din_d;
      min_q <= min_d;
      img_q <= img_d;
      mout_q <= mout_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      pg_q <= pg_d;
      sfull_q <= sfull_d;
      ver_q <= ver_d;
      trk_act_q <= trk_act_d;
      trk_enclave_control_page_q <= trk_enclave_control_page_d;
      trk_pend_q <= trk_pend_d;
      aex_q <= aex_d;
      xdone_q <= xdone_d;
      xfault_q <= xfault_d;
      xnew_q <= xnew_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign xlate_done = xdone_q;
  assign xlate_fault = xfault_q;
  assign xlate_new = xnew_q;
  assign lp_aex_flush = aex_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_block;
    exec_ok && op == OP_PAGE_BLOCK |=> pg_q[pg].valid && pg_q[pg].blocked &&
      !pg_q[pg].tracked;
  endproperty
  a_block: assert property (p_block) else $error("blocked page mapped");
  property p_fault;
    xlate_req && !xlate_cached && pg_q[xlate_page].blocked |=>
      xlate_done && xlate_fault && !xlate_new;
  endproperty
  a_fault: assert property (p_fault) else $error("no fault");
  property p_track;
    exec_ok && op == OP_TRANSLATION_TRACK |=> trk_act_q && trk_enclave_control_page_q == pg;
  endproperty
  a_track: assert property (p_track) else $error("track idle");
  property p_evict;
    exec_ok && is_evict |=> !pg_q[pg].valid && img_q == $past(cipher_c);
  endproperty
  a_evict: assert property (p_evict) else $error("evict wrong");
  property p_mac;
    exec && is_reload && mac_c != min_q |=> err_q != ERR_NONE;
  endproperty
  a_mac: assert property (p_mac) else $error("reload mac mismatch");
  property p_vslot;
    exec_ok && is_evict |-> vm_we ##1 sfull_q[slot] &&
      ver_q == $past(ver_q) + 16'h0001;
  endproperty
  a_vslot: assert property (p_vslot) else $error("version lost");
  property p_reload_state;
    exec_ok && is_reload |=> pg_q[pg].valid &&
      pg_q[pg].blocked == (op == OP_RELOAD_BLOCKED);
  endproperty
  a_reload_state: assert property (p_reload_state) else $error("blk");
  property p_slot_empty;
    exec_ok && is_reload |=> !sfull_q[slot];
  endproperty
  a_slot_empty: assert property (p_slot_empty) else $error("slot kept");
  property p_ctrl_evict;
    exec && is_evict && pg_q[pg].ptype == PT_CONTROL && child_c &&
      slot_ok && !sfull_q[slot] |->
      !exec_ok ##1 pg_q[pg].valid && err_q == ERR_CHILD;
  endproperty
  a_ctrl_evict: assert property (p_ctrl_evict) else $error("ctrl out");
  property p_add_free;
    exec && op == OP_DYNAMIC_PAGE_ADD && pg_q[pg].valid |=>
      err_q == ERR_STATE || err_q == ERR_UNSUP;
  endproperty
  a_add_free: assert property (p_add_free) else $error("add on used");
  property p_add_state;
    exec_ok && op == OP_DYNAMIC_PAGE_ADD |=> pg_q[pg].valid &&
      pg_q[pg].pending;
  endproperty
  a_add_state: assert property (p_add_state) else $error("not pending");
  property p_add_zero;
    exec_ok && op == OP_DYNAMIC_PAGE_ADD |=> pg_q[pg].ptype == PT_REGULAR &&
      pg_q[pg].data == '0;
  endproperty
  a_add_zero: assert property (p_add_zero) else $error("not zero");
  property p_accept;
    exec_ok && op == OP_ENCLAVE_ACCEPT |=> pg_q[pg].valid &&
      !pg_q[pg].pending;
  endproperty
  a_accept: assert property (p_accept) else $error("still pending");
  property p_gen2;
    exec && !GEN2_SUPPORT && (op == OP_DYNAMIC_PAGE_ADD ||
      op == OP_ENCLAVE_ACCEPT) |=> err_q == ERR_UNSUP;
  endproperty
  a_gen2: assert property (p_gen2) else $error("gen2 op allowed");
  property p_aex;
    (lp_ipi & lp_in_enclave) != '0 |=>
      lp_aex_flush == $past(lp_ipi & lp_in_enclave);
  endproperty
  a_aex: assert property (p_aex) else $error("no enclave exit");
  property p_reentry;
    trk_act_q && !(exec_ok && op == OP_TRANSLATION_TRACK) |=>
      (trk_pend_q & ~$past(trk_pend_q)) == '0;
  endproperty
  a_reentry: assert property (p_reentry) else $error("pend grew");
  property p_evict_fail;
    exec && is_evict && pg_q[pg].valid && pg_q[pg].ptype == PT_REGULAR &&
      (!pg_q[pg].blocked || !trk_done) |-> !exec_ok ##1 pg_q[pg].valid;
  endproperty
  a_evict_fail: assert property (p_evict_fail) else $error("bad evict");
endmodule // epps_core

/* File: core/epps_pkg.sv */
// package: constants and types of the enclave page paging-state block
package epps_pkg;
  localparam int NPAGES = 16;
  localparam int PG_W = 4;
  localparam int SLOT_W = 6;
  localparam int VER_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DATA_IN = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MAC_IN = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IMG_OUT = 8'h10;
  localparam logic [ADDR_W-1:0] REG_MAC_OUT = 8'h14;
  localparam logic [ADDR_W-1:0] REG_FEATURE = 8'h18;
  localparam logic [ADDR_W-1:0] REG_PAGE_INFO = 8'h1C;

  // command word field positions
  localparam int OP_LSB = 0;
  localparam int PAGE_LSB = 4;
  localparam int SLOT_LSB = 8;
  localparam int ENCLAVE_CONTROL_PAGE_LSB = 16;
  localparam int TYPE_LSB = 20;

  // reset value and MAC salt
  localparam logic [VER_W-1:0] VER_RST = 16'h0001;
  localparam logic [DATA_W-1:0] MAC_SALT = 32'hC3A50F69;

  // page operations
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_PAGE_BLOCK = 4'h1,
    OP_TRANSLATION_TRACK = 4'h2,
    OP_PAGE_EVICT = 4'h3,
    OP_RELOAD_UNBLOCKED = 4'h4,
    OP_RELOAD_BLOCKED = 4'h5,
    OP_VERSION_PAGE_CREATE = 4'h6,
    OP_DYNAMIC_PAGE_ADD = 4'h7,
    OP_ENCLAVE_ACCEPT = 4'h8,
    OP_PAGE_INSTALL = 4'h9
  } epps_op_type;

  // result codes
  typedef enum logic [3:0] {
    ERR_NONE = 4'h0,
    ERR_STATE = 4'h1,
    ERR_TRACK = 4'h2,
    ERR_MAC = 4'h3,
    ERR_SLOT = 4'h4,
    ERR_UNSUP = 4'h5,
    ERR_CHILD = 4'h6,
    ERR_PARENT = 4'h7,
    ERR_BADOP = 4'h8
  } epps_err_type;

  // page types
  typedef enum logic [1:0] {
    PT_REGULAR = 2'b00,
    PT_CONTROL = 2'b01,
    PT_VERSION = 2'b10
  } epps_ptype_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b10
  } epps_state_type;

  // one entry of the protected page cache state table
  typedef struct packed {
    logic valid;
    logic blocked;
    logic pending;
    logic tracked;
    epps_ptype_type ptype;
    logic [PG_W-1:0] owner;
    logic [DATA_W-1:0] data;
  } epps_page_type;
endpackage

/* File: core/epps_vmem.sv */
// version slot memory with registered read data
module epps_vmem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [2**AW];

  // storage write and registered read
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (rst) begin
      rdata_q <= '0;
    end else if (re) begin
      rdata_q <= mem[raddr];
    end
  end
endmodule // epps_vmem

/* File: core/epps_seal.sv */
// page sealing: keystream and integrity tag for evicted images
module epps_seal import epps_pkg::*; #(
  parameter logic [DATA_W-1:0] KEY = 32'h5A3C96E1
) (
  // binding context
  input wire logic [VER_W-1:0] version,
  input wire logic [PG_W-1:0] page,
  input wire epps_ptype_type ptype,
  input wire logic [PG_W-1:0] owner,
  // sealed image
  input wire logic [DATA_W-1:0] cipher,
  output logic [DATA_W-1:0] keystream,
  output logic [DATA_W-1:0] mac
);
  function automatic logic [DATA_W-1:0] rotl(input logic [DATA_W-1:0] x,
                                             input int n);
    return (x << n) | (x >> (DATA_W - n));
  endfunction

  // keystream binds version, page, type and owner; tag covers the image
  assign keystream = KEY ^ rotl({version, 6'h00, ptype, owner, page}, 5);
  assign mac = rotl(cipher, 7) ^ rotl(keystream, 13) ^ MAC_SALT;
endmodule // epps_seal

/* File: tb/epps_sw.sv */
// privileged software model issuing page operations on the register port
module epps_sw import epps_pkg::*; (
  // clock
  input wire logic core_clk,
  // register port
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // write cycle; released lines show inverted values, never the old ones
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // read cycle; data taken in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
  // command word carries page, slot, owner and type together
  task automatic op(input logic [DATA_W-1:0] c, output logic [DATA_W-1:0] s);
    wr(REG_CMD, c);
    @(posedge core_clk);
    rd(REG_STATUS, s);
  endtask
endmodule // epps_sw

/* File: tb/tb_enclave_page_paging_state.sv */
// self-checking bench of the paging-state engine
module tb_enclave_page_paging_state import epps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [3:0] o;
    logic [3:0] p;
    logic [5:0] sl;
    logic [1:0] t;
    logic [3:0] err;
    logic [5:0] info;
  } epps_row_type;
  logic core_clk, rst, reg_wr, reg_rd, xlate_req, xlate_cached;
  logic xlate_done, xlate_fault, xlate_new;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, s, img, tag, rdata_g1;
  logic [PG_W-1:0] xlate_page;
  logic [3:0] lp_in_enclave, lp_ipi, lp_exit, lp_aex_flush;
  int n_mismatch = 0;
  int samples_checked = 0;
  // op, page, slot, type, result, page state
  epps_row_type rows [15] = '{
    '{4'h9, 4'h0, 6'h00, 2'h1, 4'h0, 6'h11},
    '{4'h9, 4'h1, 6'h00, 2'h0, 4'h0, 6'h01},
    '{4'h6, 4'h2, 6'h00, 2'h2, 4'h0, 6'h21},
    '{4'h3, 4'h1, 6'h08, 2'h0, 4'h1, 6'h01},
    '{4'h1, 4'h1, 6'h00, 2'h0, 4'h0, 6'h03},
    '{4'h3, 4'h1, 6'h08, 2'h0, 4'h2, 6'h03},
    '{4'h2, 4'h0, 6'h00, 2'h1, 4'h0, 6'h11},
    '{4'h3, 4'h0, 6'h09, 2'h1, 4'h6, 6'h11},
    '{4'h7, 4'h3, 6'h00, 2'h0, 4'h0, 6'h05},
    '{4'h7, 4'h3, 6'h00, 2'h0, 4'h1, 6'h05},
    '{4'h8, 4'h3, 6'h00, 2'h0, 4'h0, 6'h01},
    '{4'hF, 4'h3, 6'h00, 2'h0, 4'h8, 6'h01},
    '{4'h6, 4'h4, 6'h00, 2'h2, 4'h0, 6'h21},
    '{4'h3, 4'h4, 6'h10, 2'h0, 4'h4, 6'h21},
    '{4'h3, 4'h4, 6'h0A, 2'h0, 4'h0, 6'h00}
  };

  epps_core epps_core_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .xlate_req, .xlate_page, .xlate_cached, .xlate_done,
    .xlate_fault, .xlate_new, .lp_in_enclave, .lp_ipi, .lp_exit,
    .lp_aex_flush);
  epps_sw epps_sw_inst (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  // first-generation twin on the same bus: dynamic ops must be refused
  epps_core #(.GEN2_SUPPORT(1'b0)) epps_core_g1_inst (.core_clk, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata_g1),
    .xlate_req, .xlate_page, .xlate_cached, .xlate_done(), .xlate_fault(),
    .xlate_new(), .lp_in_enclave, .lp_ipi, .lp_exit, .lp_aex_flush());

  // free-running 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // command word from its fields, owner control page 0
  function automatic logic [DATA_W-1:0] mk(input logic [3:0] o, p,
    input logic [5:0] sl, input logic [1:0] t);
    return {10'h000, t, 4'h0, 2'h0, sl, p, o};
  endfunction
  task automatic chk(input logic [DATA_W-1:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [DATA_W-1:0] c, input logic [3:0] e);
    epps_sw_inst.op(c, s);
    chk(s[3:0], e);
  endtask
  // select a page and compare its masked state
  task automatic info(input logic [3:0] p, input logic [5:0] m, e);
    epps_sw_inst.wr(REG_DATA_IN, {28'h0, p});
    epps_sw_inst.rd(REG_PAGE_INFO, s);
    chk(s[5:0] & m, e);
  endtask
  // one lookup; done, fault and new are due one cycle later
  task automatic xl(input logic [3:0] p, input logic c, input logic [1:0] e);
    @(posedge core_clk);
    xlate_req <= 1'b1;
    xlate_page <= p;
    xlate_cached <= c;
    @(posedge core_clk);
    xlate_req <= 1'b0;
    #1;
    chk({xlate_done, xlate_fault, xlate_new}, {1'b1, e});
  endtask
  // evicted image and tag read back for a later reload
  task automatic grab;
    epps_sw_inst.rd(REG_IMG_OUT, img);
    epps_sw_inst.rd(REG_MAC_OUT, tag);
    epps_sw_inst.wr(REG_DATA_IN, img);
    epps_sw_inst.wr(REG_MAC_IN, tag);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // bound on the whole run
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict;
  end
  // main sequence
  initial begin
    rst = 1'b1;
    xlate_req = 1'b0;
    xlate_page = 4'h0;
    xlate_cached = 1'b0;
    lp_in_enclave = 4'h0;
    lp_ipi = 4'h0;
    lp_exit = 4'h0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      run(mk(rows[i].o, rows[i].p, rows[i].sl, rows[i].t), rows[i].err);
      info(rows[i].p, 6'h3F, rows[i].info);
    end
    xl(4'h1, 1'b0, 2'h2);
    xl(4'h1, 1'b1, 2'h0);
    xl(4'h3, 1'b0, 2'h1);
    // evict, then reload with wrong slot, wrong tag, right pair
    run(mk(4'h3, 4'h1, 6'h08, 2'h0), 4'h0);
    info(4'h1, 6'h3F, 6'h00);
    grab;
    run(mk(4'h4, 4'h1, 6'h09, 2'h0), 4'h4);
    epps_sw_inst.wr(REG_MAC_IN, ~tag);
    run(mk(4'h4, 4'h1, 6'h08, 2'h0), 4'h3);
    epps_sw_inst.wr(REG_MAC_IN, tag);
    run(mk(4'h4, 4'h1, 6'h08, 2'h0), 4'h0);
    info(4'h1, 6'h3F, 6'h01);
    // second round with a processor inside the enclave
    @(posedge core_clk);
    lp_in_enclave <= 4'h1;
    run(mk(4'h1, 4'h1, 6'h00, 2'h0), 4'h0);
    run(mk(4'h2, 4'h0, 6'h00, 2'h1), 4'h0);
    chk(s[6:5], 2'h1);
    run(mk(4'h3, 4'h1, 6'h09, 2'h0), 4'h2);
    @(posedge core_clk);
    lp_ipi <= 4'h1;
    @(posedge core_clk);
    lp_ipi <= 4'h0;
    #1;
    chk(lp_aex_flush, 4'h1);
    epps_sw_inst.rd(REG_STATUS, s);
    chk(s[6], 1'b1);
    run(mk(4'h3, 4'h1, 6'h09, 2'h0), 4'h0);
    grab;
    run(mk(4'h4, 4'h1, 6'h08, 2'h0), 4'h4);
    run(mk(4'h5, 4'h1, 6'h09, 2'h0), 4'h0);
    info(4'h1, 6'h03, 6'h03);
    epps_sw_inst.rd(REG_FEATURE, s);
    chk(s[1:0], 2'h3);
    chk(rdata_g1[1:0], 2'h1);
    // mid-run reset clears status, tracker, exits and page table
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    epps_sw_inst.rd(REG_STATUS, s);
    chk(s, 32'h0);
    chk(lp_aex_flush, 4'h0);
    info(4'h1, 6'h3F, 6'h00);
    print_verdict;
  end
endmodule // tb_enclave_page_paging_state
